//--- design/cic_pkg.sv
// Package of constants and types for the configurable interrupt controller
package cic_pkg;
  // ****************************************************************
  // Register offsets (byte addresses, 9-bit space)
  // ****************************************************************
  localparam logic [8:0] CIC_OFF_STATUS   = 9'h000;
  localparam logic [8:0] CIC_OFF_PENDING  = 9'h004;
  localparam logic [8:0] CIC_OFF_ENABLE   = 9'h008;
  localparam logic [8:0] CIC_OFF_ACK      = 9'h00C;
  localparam logic [8:0] CIC_OFF_SET_EN   = 9'h010;
  localparam logic [8:0] CIC_OFF_CLR_EN   = 9'h014;
  localparam logic [8:0] CIC_OFF_VECTOR   = 9'h018;
  localparam logic [8:0] CIC_OFF_MASTER   = 9'h01C;
  localparam logic [8:0] CIC_OFF_LEVEL    = 9'h024;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          CIC_MASTER_ME_BIT  = 0;
  localparam int          CIC_MASTER_HIE_BIT = 1;
  localparam logic [31:0] CIC_RST_ENABLE     = 32'h0000_0000;
  localparam logic [31:0] CIC_RST_STATUS     = 32'h0000_0000;
  localparam logic [1:0]  CIC_RST_MASTER     = 2'h0;
  localparam logic [31:0] CIC_RST_LEVEL      = 32'hFFFF_FFFF;
  localparam logic [31:0] CIC_VECTOR_NONE    = 32'hFFFF_FFFF;
  localparam int          CIC_CASCADE_BIT    = 31;
  // ****************************************************************
  // Build-time defaults
  // ****************************************************************
  localparam int          CIC_DATA_W         = 32;
  localparam int          CIC_ADDR_W         = 9;
  localparam int          CIC_MAX_SYNC       = 7;
  localparam int          CIC_DEF_NUM_IN     = 1;
  localparam int          CIC_DEF_SYNC       = 2;
  localparam logic [31:0] CIC_ALL_ONES       = 32'hFFFF_FFFF;
  localparam logic [31:0] CIC_DEF_VEC_BASE   = 32'h0000_0000;
  localparam logic [31:0] CIC_DEF_VEC_STRIDE = 32'h0000_0004;
  // ****************************************************************
  // Processor acknowledge codes
  // ****************************************************************
  localparam logic [1:0]  CIC_ACK_NONE       = 2'h0;
  localparam logic [1:0]  CIC_ACK_BRANCH     = 2'h1;
  localparam logic [1:0]  CIC_ACK_RETURN     = 2'h2;
  localparam logic [1:0]  CIC_ACK_REENABLE   = 2'h3;

  typedef enum logic [3:0] {
    CIC_REG_STATUS, CIC_REG_PENDING, CIC_REG_ENABLE, CIC_REG_ACK, CIC_REG_SET_EN,
    CIC_REG_CLR_EN, CIC_REG_VECTOR, CIC_REG_MASTER, CIC_REG_LEVEL, CIC_REG_NONE
  } cic_reg_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [8:0]  paddr;
    logic [31:0] pwdata;
  } cic_apb_req_s;

  typedef struct packed {
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
  } cic_apb_rsp_s;

  typedef struct packed {
    logic [6:0][31:0] chain;
    logic [31:0]      prev;
    logic [31:0]      status;
    logic [31:0]      enable;
    logic [1:0]       master;
    logic [31:0]      level;
    logic             in_service;
    logic [1:0]       cpu_sync;
    logic             src_q;
    logic             irq_pin;
    logic [31:0]      vec_addr;
    logic [1:0]       ack_out;
    logic [31:0]      rdata;
    logic             slverr;
  } cic_state_s;
endpackage

//--- design/cic_top.sv
// Configurable interrupt controller with APB register port
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module cic_top
  import cic_pkg::*;
#(
  parameter int          NUM_IN         = CIC_DEF_NUM_IN,
  parameter logic [31:0] EDGE_SELECT    = CIC_ALL_ONES,
  parameter logic [31:0] EDGE_POL       = CIC_ALL_ONES,
  parameter logic [31:0] LEVEL_POL      = CIC_ALL_ONES,
  parameter logic [31:0] ASYNC_SELECT   = CIC_ALL_ONES,
  parameter int          SYNC_STAGES    = CIC_DEF_SYNC,
  parameter int          SW_COUNT       = 0,
  parameter bit          PENDING_PRES   = 1'b1,
  parameter bit          SET_EN_PRES    = 1'b1,
  parameter bit          CLR_EN_PRES    = 1'b1,
  parameter bit          VECTOR_PRES    = 1'b1,
  parameter bit          LEVEL_PRES     = 1'b0,
  parameter bit          REQ_IS_LEVEL   = 1'b1,
  parameter bit          REQ_ACTIVE     = 1'b1,
  parameter bit          CPU_CLK_ABSENT = 1'b1,
  parameter bit          SYNC_DISABLE   = 1'b1,
  parameter bit          FAST_PRES      = 1'b0,
  parameter bit          SINGLE_OUT     = 1'b0,
  parameter bit          CASCADE_EN     = 1'b0,
  parameter bit          CASCADE_MASTER = 1'b0,
  parameter logic [31:0] VEC_BASE       = CIC_DEF_VEC_BASE,
  parameter logic [31:0] VEC_STRIDE     = CIC_DEF_VEC_STRIDE
) (
  input  wire logic              ref_clk,           // Bus clock
  input  wire logic              srst,              // Synchronous reset, high
  input  wire logic              psel,              // APB select
  input  wire logic              penable,           // APB enable
  input  wire logic              pwrite,            // APB direction
  input  wire logic [8:0]        paddr,             // APB byte address
  input  wire logic [31:0]       pwdata,            // APB write data
  output logic                   pready,            // APB ready
  output logic [31:0]            prdata,            // APB read data
  output logic                   pslverr,           // APB error
  input  wire logic [NUM_IN-1:0] intr,              // Peripheral interrupt lines
  input  wire logic              irq_in,            // Request of downstream instance
  input  wire logic [1:0]        processor_ack,     // Processor acknowledge code
  output logic                   irq,               // Interrupt request output
  output logic [31:0]            interrupt_address, // Fast vector address
  output logic [1:0]             processor_ack_out  // Acknowledge passed downstream
);
  // ****************************************************************
  // Configuration derived values
  // ****************************************************************
  localparam int SYNC_D   = (SYNC_STAGES > 0) ? SYNC_STAGES : 1;
  localparam bit USE_SYNC = !CPU_CLK_ABSENT && !SYNC_DISABLE;
  localparam bit CFG_OK   = (NUM_IN >= 1) && (NUM_IN <= 32) && (SW_COUNT <= 31)
                            && (NUM_IN + SW_COUNT <= 32) && (SYNC_STAGES <= CIC_MAX_SYNC)
                            && (!FAST_PRES || (!CPU_CLK_ABSENT && !SINGLE_OUT))
                            && (!CASCADE_MASTER || CASCADE_EN);

  cic_state_s   r;
  cic_state_s   next_r;
  cic_apb_req_s req;
  logic [31:0]  raw;
  logic [31:0]  synced;
  logic [31:0]  hw_mask;
  logic [31:0]  sw_mask;
  logic [31:0]  event_hit;
  logic [31:0]  level_mask;
  logic [31:0]  pend;
  logic [5:0]   vec_idx;
  logic         core_req;
  logic         src;
  logic         assert_lvl;
  cic_reg_e     wr_sel;
  cic_reg_e     rd_sel;

  // Register decode, honouring optional presence
  function automatic cic_reg_e decode(input logic [8:0] a);
    if (a == CIC_OFF_STATUS) begin
      return CIC_REG_STATUS;
    end else if (a == CIC_OFF_PENDING && PENDING_PRES) begin
      return CIC_REG_PENDING;
    end else if (a == CIC_OFF_ENABLE) begin
      return CIC_REG_ENABLE;
    end else if (a == CIC_OFF_ACK) begin
      return CIC_REG_ACK;
    end else if (a == CIC_OFF_SET_EN && SET_EN_PRES) begin
      return CIC_REG_SET_EN;
    end else if (a == CIC_OFF_CLR_EN && CLR_EN_PRES) begin
      return CIC_REG_CLR_EN;
    end else if (a == CIC_OFF_VECTOR && VECTOR_PRES) begin
      return CIC_REG_VECTOR;
    end else if (a == CIC_OFF_MASTER) begin
      return CIC_REG_MASTER;
    end else if (a == CIC_OFF_LEVEL && LEVEL_PRES) begin
      return CIC_REG_LEVEL;
    end else begin
      return CIC_REG_NONE;
    end
  endfunction

  // Lowest set bit wins; bit 5 flags nothing set
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] idx;
    idx = 6'h20;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign wr_sel = decode(req.paddr);
  assign rd_sel = decode(req.paddr);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  always_comb begin
    raw = '0;
    raw[NUM_IN-1:0] = intr;
    for (int i = 0; i < 32; i++) begin
      hw_mask[i] = (i < NUM_IN);
      sw_mask[i] = (i >= NUM_IN) && (i < NUM_IN + SW_COUNT);
      level_mask[i] = !LEVEL_PRES || (32'(i) < r.level);
    end
  end

  // Synced view per input: async lines use chain stage SYNC_STAGES-1
  generate
    for (genvar g = 0; g < 32; g++) begin : g_in
      if (ASYNC_SELECT[g] && SYNC_STAGES > 0) begin : g_async
        assign synced[g] = r.chain[SYNC_STAGES-1][g];
      end else begin : g_sync
        assign synced[g] = raw[g];
      end
    end
  endgenerate

  // Edge or level detection per bit; bit n uses configuration bit n
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (EDGE_SELECT[i]) begin
        event_hit[i] = EDGE_POL[i] ? (synced[i] & ~r.prev[i])
                                   : (~synced[i] & r.prev[i]);
      end else begin
        event_hit[i] = ~(synced[i] ^ LEVEL_POL[i]);
      end
    end
    event_hit = event_hit & hw_mask;
    if (CASCADE_EN) begin
      event_hit[CIC_CASCADE_BIT] = irq_in;
    end
  end

  // ****************************************************************
  // Request and priority
  // ****************************************************************
  assign pend       = r.status & r.enable & level_mask;
  assign vec_idx    = first_set(pend);
  assign core_req   = r.master[CIC_MASTER_ME_BIT] && (|pend) && !r.in_service;
  assign src        = USE_SYNC ? r.cpu_sync[1] : core_req;
  assign assert_lvl = REQ_IS_LEVEL ? src : (src & ~r.src_q);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] clr;
    logic        acc;
    clr    = '0;
    acc    = req.psel && req.penable;
    next_r = r;
    next_r.chain[0] = raw;
    for (int s = 1; s < CIC_MAX_SYNC; s++) begin
      next_r.chain[s] = r.chain[s-1];
    end
    next_r.prev = synced;
    if (acc && req.pwrite) begin
      if (wr_sel == CIC_REG_STATUS) begin
        // Hardware bits writable only until the hardware enable is set
        next_r.status = r.status | (req.pwdata & (sw_mask
                        | (r.master[CIC_MASTER_HIE_BIT] ? '0 : hw_mask)));
      end else if (wr_sel == CIC_REG_ENABLE) begin
        next_r.enable = req.pwdata & (hw_mask | sw_mask | (CASCADE_EN ? 32'h8000_0000 : '0));
      end else if (wr_sel == CIC_REG_ACK) begin
        clr = req.pwdata;
      end else if (wr_sel == CIC_REG_SET_EN) begin
        // Same source mask as a direct enable write, cascade bit included
        next_r.enable = r.enable | (req.pwdata & (hw_mask | sw_mask | (CASCADE_EN ? 32'h8000_0000 : '0)));
      end else if (wr_sel == CIC_REG_CLR_EN) begin
        next_r.enable = r.enable & ~req.pwdata;
      end else if (wr_sel == CIC_REG_MASTER) begin
        // Hardware enable is sticky once set
        next_r.master[CIC_MASTER_ME_BIT]  = req.pwdata[CIC_MASTER_ME_BIT];
        next_r.master[CIC_MASTER_HIE_BIT] = r.master[CIC_MASTER_HIE_BIT] | req.pwdata[CIC_MASTER_HIE_BIT];
      end else if (wr_sel == CIC_REG_LEVEL) begin
        next_r.level = req.pwdata;
      end
    end
    if (FAST_PRES) begin
      case (processor_ack)
        CIC_ACK_BRANCH: begin
          next_r.in_service = 1'b1;
          if (!vec_idx[5]) begin
            clr[vec_idx[4:0]] = 1'b1;
          end
        end
        CIC_ACK_REENABLE: begin
          next_r.in_service = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // New event beats a clear in the same cycle
    next_r.status = (next_r.status & ~clr) | event_hit;
    next_r.cpu_sync = {r.cpu_sync[0], core_req};
    next_r.src_q    = src;
    next_r.irq_pin  = REQ_ACTIVE ? assert_lvl : ~assert_lvl;
    // Only a fast, bus-connected instance drives a vector
    if (FAST_PRES && !SINGLE_OUT && !vec_idx[5]) begin
      next_r.vec_addr = VEC_BASE + (32'(vec_idx[4:0]) * VEC_STRIDE);
    end else begin
      next_r.vec_addr = '0;
    end
    if (FAST_PRES && CASCADE_EN && CASCADE_MASTER && vec_idx == 6'(CIC_CASCADE_BIT)) begin
      next_r.ack_out = processor_ack;
    end else begin
      next_r.ack_out = CIC_ACK_NONE;
    end
    // Read data captured in the setup phase
    if (req.psel && !req.penable) begin
      next_r.slverr = (rd_sel == CIC_REG_NONE);
      next_r.rdata  = '0;
      if (!req.pwrite) begin
        case (rd_sel)
          CIC_REG_STATUS:  next_r.rdata = r.status;
          CIC_REG_PENDING: next_r.rdata = pend;
          CIC_REG_ENABLE:  next_r.rdata = r.enable;
          CIC_REG_VECTOR:  next_r.rdata = vec_idx[5] ? CIC_VECTOR_NONE : 32'(vec_idx[4:0]);
          CIC_REG_MASTER:  next_r.rdata = 32'(r.master);
          CIC_REG_LEVEL:   next_r.rdata = r.level;
          default:         next_r.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r            <= '0;
      r.status     <= CIC_RST_STATUS;
      r.enable     <= CIC_RST_ENABLE;
      r.master     <= CIC_RST_MASTER;
      r.level      <= CIC_RST_LEVEL;
      r.irq_pin    <= ~REQ_ACTIVE;
    end else begin
      r <= next_r;
    end
  end

  // Cascaded non-master instances feed the upstream, not the processor
  assign pready            = 1'b1;
  assign prdata            = r.rdata;
  assign pslverr           = r.slverr;
  assign irq               = r.irq_pin;
  assign interrupt_address = r.vec_addr;
  assign processor_ack_out = r.ack_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_cfg;
    1'b1 |-> CFG_OK;
  endproperty
  a_p_cfg: assert property (p_cfg) else $error("illegal build configuration");

  property p_prio;
    (pend != '0) |-> (pend[vec_idx[4:0]] && ((pend & ((32'h1 << vec_idx[4:0]) - 32'h1)) == '0));
  endproperty
  a_p_prio: assert property (p_prio) else $error("vector is not lowest pending");

  property p_unused;
    (r.status & ~(hw_mask | sw_mask | (CASCADE_EN ? 32'h8000_0000 : '0))) == '0;
  endproperty
  a_p_unused: assert property (p_unused) else $error("status set on absent source");

  property p_edge_in;
    (EDGE_SELECT[0] && EDGE_POL[0] && synced[0] && !r.prev[0]) |=> r.status[0];
  endproperty
  a_p_edge_in: assert property (p_edge_in) else $error("rising edge not captured");

  property p_sync_lat;
    (ASYNC_SELECT[0] && SYNC_STAGES > 0) |-> (synced[0] == $past(raw[0], SYNC_D));
  endproperty
  a_p_sync_lat: assert property (p_sync_lat) else $error("sync chain length wrong");

  property p_req_level;
    (REQ_IS_LEVEL && !USE_SYNC && core_req) |=> (irq == REQ_ACTIVE) throughout 1'b1;
  endproperty
  a_p_req_level: assert property (p_req_level) else $error("level request not driven");

  property p_req_edge;
    (!REQ_IS_LEVEL && irq == REQ_ACTIVE) |=> (irq != REQ_ACTIVE);
  endproperty
  a_p_req_edge: assert property (p_req_edge) else $error("edge request longer than a cycle");

  property p_sync_delay;
    (USE_SYNC && $rose(core_req)) |-> ##3 (REQ_IS_LEVEL ? irq == REQ_ACTIVE : 1'b1);
  endproperty
  a_p_sync_delay: assert property (p_sync_delay) else $error("synchronised request late");

  property p_absent_reg;
    (psel && !penable && paddr == CIC_OFF_PENDING && !PENDING_PRES) |=> pslverr;
  endproperty
  a_p_absent_reg: assert property (p_absent_reg) else $error("absent register answered");

  property p_fast_ack;
    (FAST_PRES && processor_ack == CIC_ACK_BRANCH) |=> (r.in_service && !core_req);
  endproperty
  a_p_fast_ack: assert property (p_fast_ack) else $error("branch ack not honoured");

  property p_no_master;
    !(CASCADE_EN && CASCADE_MASTER) |-> (processor_ack_out == CIC_ACK_NONE);
  endproperty
  a_p_no_master: assert property (p_no_master) else $error("non-master drives processor");
endmodule // cic_top

//--- sim/cic_cpu_model.sv
// Processor core model that answers fast-mode interrupt requests
`timescale 1ns/100ps
module cic_cpu_model
  import cic_pkg::*;
(
  input  wire logic       ref_clk,           // Bus clock
  input  wire logic       auto_en,           // Answer requests while high
  input  wire logic       irq,               // Request from controller
  input  wire logic [1:0] processor_ack_out, // Acknowledge passed downstream
  output logic      [1:0] processor_ack,     // Acknowledge code to controller
  output logic      [1:0] echo               // Downstream copy of last branch code
);
  // ****************************************************************
  // Handler entry and exit
  // ****************************************************************
  initial begin
    processor_ack = CIC_ACK_NONE;
    echo          = CIC_ACK_NONE;
    forever begin
      @(posedge ref_clk);
      if (auto_en && irq === 1'h1) begin
        // Prompt and slow answers both occur
        repeat ($urandom_range(3)) @(posedge ref_clk);
        processor_ack <= CIC_ACK_BRANCH;
        @(posedge ref_clk);
        processor_ack <= CIC_ACK_NONE;
        @(posedge ref_clk);
        echo <= processor_ack_out;
        repeat (2) @(posedge ref_clk);
        processor_ack <= CIC_ACK_RETURN;
        @(posedge ref_clk);
        processor_ack <= CIC_ACK_REENABLE;
        @(posedge ref_clk);
        processor_ack <= CIC_ACK_NONE;
      end
    end
  end
endmodule // cic_cpu_model

//--- sim/tb.sv
// Self-checking testbench of the interrupt controller
`timescale 1ns/100ps
module tb;
  import cic_pkg::*;
  localparam logic [31:0] VBASE = 32'h0000_1000;
  // Mixed sensitivities: 0 rising async, 1 level high, 2 falling, 3 level low
  localparam int          NIN    = 4;
  localparam logic [31:0] EDGES  = 32'h0000_0005;
  localparam logic [31:0] EPOL   = 32'hFFFF_FFFB;
  localparam logic [31:0] LPOL   = 32'hFFFF_FFF7;
  localparam logic [31:0] ASYNCS = 32'h0000_0001;
  localparam int          NSW    = 2;
  localparam bit          CASC   = 1'h1;
  typedef struct packed {
    logic [31:0] data;
    logic        err;
  } cic_exp_s;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, irq, irq_in, auto_en;
  logic [8:0]  paddr;
  logic [31:0] pwdata, prdata, interrupt_address, v;
  logic [3:0]  intr;
  logic [1:0]  processor_ack, processor_ack_out, echo;
  int          err_count = 0;
  int          comparisons = 0;
  cic_exp_s    exp_q[$];
  cic_exp_s    got;

  cic_top #(.NUM_IN(NIN), .EDGE_SELECT(EDGES), .EDGE_POL(EPOL), .LEVEL_POL(LPOL),
    .ASYNC_SELECT(ASYNCS), .SW_COUNT(NSW), .LEVEL_PRES(1'h1), .CPU_CLK_ABSENT(1'h0), .FAST_PRES(1'h1),
    .CASCADE_EN(CASC), .CASCADE_MASTER(CASC), .VEC_BASE(VBASE)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .intr(intr), .irq_in(irq_in),
    .processor_ack(processor_ack), .irq(irq), .interrupt_address(interrupt_address),
    .processor_ack_out(processor_ack_out));

  cic_cpu_model i_cpu (.ref_clk(ref_clk), .auto_en(auto_en), .irq(irq),
    .processor_ack_out(processor_ack_out), .processor_ack(processor_ack), .echo(echo));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for ready without a limit of its own; the watchdog ends a hang
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back('{data: d, err: e});
    xfer(1'h0, a, 32'h0);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk("irq", {31'h0, lvl}, {31'h0, irq});
  endtask

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Read data monitor
  // ****************************************************************
  always @(posedge ref_clk) begin
    // Every access is zero-wait
    if (psel === 1'h1 && penable === 1'h1) begin
      chk("pready", 32'h1, {31'h0, pready});
    end
    if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0) begin
      got = exp_q.pop_front();
      chk("prdata", got.data, prdata);
      chk("pslverr", {31'h0, got.err}, {31'h0, pslverr});
    end
  end

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_count++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {srst, psel, penable, pwrite, irq_in, auto_en} = 6'h20;
    paddr  = 9'h000;
    pwdata = 32'h0;
    intr   = 4'hC;
    void'($urandom(32'hA108));
    repeat (4) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    rd(CIC_OFF_STATUS, CIC_RST_STATUS, 1'h0);
    rd(CIC_OFF_ENABLE, CIC_RST_ENABLE, 1'h0);
    rd(CIC_OFF_MASTER, {30'h0, CIC_RST_MASTER}, 1'h0);
    rd(CIC_OFF_LEVEL, CIC_RST_LEVEL, 1'h0);
    rd(CIC_OFF_VECTOR, CIC_VECTOR_NONE, 1'h0);
    rd(CIC_OFF_PENDING, 32'h0, 1'h0);
    rd(9'h020, 32'h0, 1'h1);
    rd(9'h1FC, 32'h0, 1'h1);
    chk("irq", 32'h0, {31'h0, irq});
    xfer(1'h1, CIC_OFF_SET_EN, 32'h0000_000F);
    xfer(1'h1, CIC_OFF_CLR_EN, 32'h0000_0002);
    rd(CIC_OFF_ENABLE, 32'h0000_000D, 1'h0);
    xfer(1'h1, CIC_OFF_SET_EN, 32'h8000_0032);
    rd(CIC_OFF_ENABLE, 32'h8000_003F, 1'h0);
    xfer(1'h1, CIC_OFF_MASTER, 32'h0000_0003);
    rd(CIC_OFF_MASTER, 32'h0000_0003, 1'h0);
    // Input 0 rises, input 2 falls in the same cycle
    intr <= 4'h9;
    wait_irq(1'h1);
    repeat (4) @(posedge ref_clk);
    rd(CIC_OFF_STATUS, 32'h0000_0005, 1'h0);
    rd(CIC_OFF_VECTOR, 32'h0, 1'h0);
    chk("interrupt_address", VBASE, interrupt_address);
    xfer(1'h1, CIC_OFF_ACK, 32'h0000_0001);
    rd(CIC_OFF_STATUS, 32'h0000_0004, 1'h0);
    rd(CIC_OFF_VECTOR, 32'h2, 1'h0);
    chk("interrupt_address", VBASE + 32'h8, interrupt_address);
    xfer(1'h1, CIC_OFF_ACK, 32'h0000_0004);
    rd(CIC_OFF_VECTOR, CIC_VECTOR_NONE, 1'h0);
    wait_irq(1'h0);
    // Level inputs: 1 active high, 3 active low
    intr <= 4'h3;
    repeat (4) @(posedge ref_clk);
    rd(CIC_OFF_STATUS, 32'h0000_000A, 1'h0);
    xfer(1'h1, CIC_OFF_ACK, 32'h0000_000A);
    rd(CIC_OFF_STATUS, 32'h0000_000A, 1'h0);
    intr <= 4'h9;
    repeat (2) @(posedge ref_clk);
    xfer(1'h1, CIC_OFF_ACK, 32'h0000_000A);
    rd(CIC_OFF_STATUS, 32'h0, 1'h0);
    // Software sources sit above the hardware inputs
    v = ($urandom() & 32'h30) | 32'h1;
    xfer(1'h1, CIC_OFF_STATUS, v);
    rd(CIC_OFF_STATUS, v & 32'h30, 1'h0);
    xfer(1'h1, CIC_OFF_ACK, 32'h30);
    intr <= 4'hB;
    repeat (4) @(posedge ref_clk);
    xfer(1'h1, CIC_OFF_LEVEL, 32'h1);
    rd(CIC_OFF_PENDING, 32'h0, 1'h0);
    xfer(1'h1, CIC_OFF_LEVEL, 32'h2);
    rd(CIC_OFF_PENDING, 32'h2, 1'h0);
    xfer(1'h1, CIC_OFF_LEVEL, CIC_RST_LEVEL);
    intr <= 4'h9;
    repeat (2) @(posedge ref_clk);
    xfer(1'h1, CIC_OFF_ACK, 32'h2);
    rd(CIC_OFF_STATUS, 32'h0, 1'h0);
    // Processor answers in fast mode
    auto_en <= 1'h1;
    intr    <= 4'h8;
    @(posedge ref_clk);
    intr <= 4'h9;
    repeat (16) @(posedge ref_clk);
    rd(CIC_OFF_STATUS, 32'h0, 1'h0);
    // Downstream instance raises its request
    irq_in <= 1'h1;
    repeat (20) @(posedge ref_clk);
    irq_in  <= 1'h0;
    auto_en <= 1'h0;
    repeat (12) @(posedge ref_clk);
    chk("processor_ack_out", {30'h0, CIC_ACK_BRANCH}, {30'h0, echo});
    xfer(1'h1, CIC_OFF_ACK, 32'h8000_0000);
    rd(CIC_OFF_STATUS, 32'h0, 1'h0);
    wait_irq(1'h0);
    // Direct enable write keeps only the sources that exist
    xfer(1'h1, CIC_OFF_ENABLE, 32'hFFFF_FFFF);
    rd(CIC_OFF_ENABLE, 32'h8000_003F, 1'h0);
    conclude();
  end
endmodule // tb
